// *** fsps_pkg.sv ***
package fsps_pkg;
    localparam int CLK_MHZ = 125;
    localparam int PROG_MIN_US = 3700;
    localparam int PROG_MAX_US = 4500;
    localparam int PROG_CYCLES_DEF = PROG_MIN_US * CLK_MHZ;
    localparam int SPM_WINDOW = 4;
    localparam int WORD_BITS = 6;
    localparam int PAGE_BITS = 8;
    localparam int PAGE_WORDS = 64;
    localparam int ZPTR_WORD_LSB = 1;
    localparam int ZPTR_PAGE_LSB = ZPTR_WORD_LSB + WORD_BITS;
    localparam logic [7:0] CMD_LOAD = 8'h01;
    localparam logic [7:0] CMD_ERASE = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h05;
    localparam logic [7:0] CMD_REENABLE = 8'h11;
    localparam logic [7:0] CMD_IDLE = 8'h00;
    localparam logic [15:0] WORD_ERASED = 16'hffff;
    localparam logic [2:0] WB_CTRL = 3'h0;
    localparam logic [2:0] WB_ZPTR = 3'h1;
    localparam logic [2:0] WB_DATA = 3'h2;
    localparam logic [2:0] WB_STATUS = 3'h3;
    localparam logic [2:0] WB_RDADDR = 3'h4;
    localparam logic [2:0] WB_RDDATA = 3'h5;
    localparam logic [31:0] WB_UNMAPPED = 32'h0;
    typedef enum logic [1:0] {FSPS_IDLE, FSPS_ARMED, FSPS_PROG} fsps_state_t;
endpackage

// *** fsps_if.sv ***
interface fsps_if;
    logic [7:0] ctrlWr;
    logic ctrlWe;
    logic spmExec;
    logic [15:0] zPtr;
    logic [15:0] dataWord;
    logic eepromBusy;
    logic cpuHalt;
    logic [7:0] ctrlRd;
    logic [fsps_pkg::PAGE_BITS+fsps_pkg::WORD_BITS-1:0] rdAddr;
    logic [15:0] rdData;
    modport device (input ctrlWr, ctrlWe, spmExec, zPtr, dataWord, eepromBusy, rdAddr,
        output cpuHalt, ctrlRd, rdData);
    modport host (output ctrlWr, ctrlWe, spmExec, zPtr, dataWord, eepromBusy, rdAddr,
        input cpuHalt, ctrlRd, rdData);
endinterface

// *** fsps_device.sv ***
// Operation
// - Whole-page update; erase before page write
// - One word loaded per store instruction
// - Buffer words load in any order
// - Erase code then instruction within four cycles
// - Erase uses page field only, ignores data
// - CPU halted throughout page erase
// - Load code then instruction within four cycles
// - Word-in-page field selects buffer word
// - Buffer cleared after write, reenable, reset
// - Controller loads each word once per clear; the code rewrites the slot on every load
// - EEPROM write discards loaded buffer data
// - Write code then instruction; data ignored
// - Controller zeroes non-page Z bits on write; the code leaves them and ignores them
// - CPU halted throughout page write
// - Store instruction accepted from any address
// - Controller uses same page for erase/write
// - EEPROM write blocks all self-programming
// - Erase/write lasts minimum programming time
//
// Implementation choices: the address map and register access over Wishbone.
module fsps_device #(
    parameter int PROG_CYCLES = fsps_pkg::PROG_CYCLES_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Core side
    fsps_if.device core
);
    import fsps_pkg::*;

    // Arming and programming state
    fsps_state_t state_ff;
    logic [7:0] cmd_ff;
    logic [2:0] win_ff;
    logic [31:0] progCnt_ff;
    logic isErase_ff;
    logic [PAGE_BITS-1:0] progPage_ff;
    // Temporary page buffer and page array
    logic [15:0] buf_ff [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] bufValid_ff;
    // Word-major, so each generated word slice has a single writer
    logic [15:0] mem_ff [PAGE_WORDS][1 << PAGE_BITS];
    logic [15:0] rdData_ff;
    // Decoded command and link events
    logic armReq;
    logic fire;
    logic expire;
    logic cmdLoad;
    logic cmdErase;
    logic cmdWrite;
    logic cmdReenable;
    logic progStart;
    logic loadWord;
    logic [WORD_BITS-1:0] zWord;
    logic [PAGE_BITS-1:0] zPage;
    logic [WORD_BITS-1:0] rdWord;
    logic [PAGE_BITS-1:0] rdPage;
    logic progDone;
    logic writeDone;
    logic bufClear;

    assign zWord = core.zPtr[ZPTR_WORD_LSB +: WORD_BITS];
    assign zPage = core.zPtr[ZPTR_PAGE_LSB +: PAGE_BITS];
    assign rdWord = core.rdAddr[0 +: WORD_BITS];
    assign rdPage = core.rdAddr[WORD_BITS +: PAGE_BITS];
    assign cmdLoad = (cmd_ff == CMD_LOAD);
    assign cmdErase = (cmd_ff == CMD_ERASE);
    assign cmdWrite = (cmd_ff == CMD_WRITE);
    assign cmdReenable = (cmd_ff == CMD_REENABLE);
    // Writes while EEPROM busy are dropped, not queued
    assign armReq = (state_ff == FSPS_IDLE) && core.ctrlWe && !core.eepromBusy;
    // Any fetch address may issue the instruction; no section check
    assign fire = (state_ff == FSPS_ARMED) && core.spmExec && !core.eepromBusy;
    // No store instruction in time, or EEPROM busy while armed: drop the command
    assign expire = (state_ff == FSPS_ARMED) && !fire
        && (win_ff == 3'(SPM_WINDOW - 1) || core.eepromBusy);
    assign progStart = fire && (cmdErase || cmdWrite);
    assign loadWord = fire && cmdLoad;
    assign progDone = (state_ff == FSPS_PROG) && (progCnt_ff == 32'(PROG_CYCLES - 1));
    assign writeDone = progDone && !isErase_ff;
    assign bufClear = writeDone || (fire && cmdReenable)
        || core.eepromBusy;
    assign core.cpuHalt = (state_ff == FSPS_PROG);
    assign core.ctrlRd = cmd_ff;
    assign core.rdData = rdData_ff;

    // Sequencer state
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff <= FSPS_IDLE;
        end else begin
            unique case (state_ff)
                FSPS_IDLE: begin
                    if (armReq) begin
                        state_ff <= FSPS_ARMED;
                    end
                end
                FSPS_ARMED: begin
                    if (progStart) begin
                        state_ff <= FSPS_PROG;
                    end else if (fire || expire) begin
                        state_ff <= FSPS_IDLE;
                    end
                end
                FSPS_PROG: begin
                    if (progDone) begin
                        state_ff <= FSPS_IDLE;
                    end
                end
                default: begin
                    state_ff <= FSPS_IDLE;
                end
            endcase
        end
    end

    // Armed command code, back to idle once used, expired or refused
    always_ff @(posedge mclk) begin
        if (srst) begin
            cmd_ff <= CMD_IDLE;
        end else begin
            unique case (state_ff)
                FSPS_IDLE: begin
                    if (armReq) begin
                        cmd_ff <= core.ctrlWr;
                    end
                end
                FSPS_ARMED: begin
                    if ((fire && !progStart) || expire) begin
                        cmd_ff <= CMD_IDLE;
                    end
                end
                FSPS_PROG: begin
                    if (progDone) begin
                        cmd_ff <= CMD_IDLE;
                    end
                end
                default: begin
                    cmd_ff <= CMD_IDLE;
                end
            endcase
        end
    end

    // Cycles since arming; four chances for the store instruction
    always_ff @(posedge mclk) begin
        if (srst || armReq) begin
            win_ff <= '0;
        end else if (state_ff == FSPS_ARMED && !fire && !expire) begin
            win_ff <= win_ff + 3'h1;
        end
    end

    // Programming timer; fixed length, no feedback from the array
    always_ff @(posedge mclk) begin
        if (srst || progStart) begin
            progCnt_ff <= '0;
        end else if (state_ff == FSPS_PROG) begin
            progCnt_ff <= progCnt_ff + 32'h1;
        end
    end

    // Operation kind and target page, taken with the store instruction
    always_ff @(posedge mclk) begin
        if (srst) begin
            isErase_ff <= 1'b0;
            progPage_ff <= '0;
        end else if (progStart) begin
            isErase_ff <= cmdErase;
            progPage_ff <= zPage;
        end
    end

    // Buffer slot and page array column per word
    genvar gw;
    generate
        for (gw = 0; gw < PAGE_WORDS; gw++) begin : g_word
            // Load goes to the addressed slot only, in any order
            always_ff @(posedge mclk) begin
                if (srst || bufClear) begin
                    bufValid_ff[gw] <= 1'b0;
                end else if (loadWord && zWord == WORD_BITS'(gw)) begin
                    bufValid_ff[gw] <= 1'b1;
                end
            end

            always_ff @(posedge mclk) begin
                if (loadWord && zWord == WORD_BITS'(gw)) begin
                    buf_ff[gw] <= core.dataWord;
                end
            end

            // Array word, updated only at the end of the programming time
            always_ff @(posedge mclk) begin
                if (progDone && isErase_ff) begin
                    mem_ff[gw][progPage_ff] <= WORD_ERASED;
                end else if (progDone) begin
                    // Programming only clears bits, so an unerased page ends as old data AND new data
                    mem_ff[gw][progPage_ff] <= mem_ff[gw][progPage_ff]
                        & (bufValid_ff[gw] ? buf_ff[gw] : WORD_ERASED);
                end
            end
        end
    endgenerate

    // Array read port, one cycle latency
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdData_ff <= '0;
        end else begin
            rdData_ff <= mem_ff[rdWord][rdPage];
        end
    end
endmodule // fsps_device

// *** fsps_host.sv ***
module fsps_host (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device side
    fsps_if.host dev
);
    import fsps_pkg::*;

    logic ack_ff;
    logic [31:0] dat_ff;
    logic [15:0] zPtr_ff;
    logic [15:0] data_ff;
    logic [7:0] ctrl_ff;
    logic ctrlWe_ff;
    logic spm_ff;
    logic busy_ff;
    logic eeBusy_ff;
    logic [PAGE_BITS+WORD_BITS-1:0] rdAddr_ff;
    logic req;
    logic wrCtrl;
    logic [2:0] idx;

    assign idx = wb_adr_i[4:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wrCtrl = req && wb_we_i && idx == WB_CTRL && wb_sel_i[0];
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign dev.zPtr = zPtr_ff;
    assign dev.dataWord = data_ff;
    assign dev.ctrlWr = ctrl_ff;
    assign dev.ctrlWe = ctrlWe_ff;
    assign dev.spmExec = spm_ff;
    assign dev.eepromBusy = eeBusy_ff;
    assign dev.rdAddr = rdAddr_ff;

    // Bus answer one cycle after request
    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end else begin
            ack_ff <= req;
            if (req && !wb_we_i) begin
                unique case (idx)
                    WB_CTRL: dat_ff <= {24'h0, dev.ctrlRd};
                    WB_ZPTR: dat_ff <= {16'h0, zPtr_ff};
                    WB_DATA: dat_ff <= {16'h0, data_ff};
                    WB_STATUS: dat_ff <= {29'h0, eeBusy_ff, busy_ff, dev.cpuHalt};
                    WB_RDADDR: dat_ff <= 32'(rdAddr_ff);
                    WB_RDDATA: dat_ff <= {16'h0, dev.rdData};
                    default: dat_ff <= WB_UNMAPPED;
                endcase
            end
        end
    end

    // Operand registers; Z and data set before the command
    always_ff @(posedge mclk) begin
        if (srst) begin
            zPtr_ff <= '0;
            data_ff <= '0;
            rdAddr_ff <= '0;
            eeBusy_ff <= 1'b0;
        end else if (req && wb_we_i) begin
            if (idx == WB_ZPTR) begin
                zPtr_ff <= wb_dat_i[15:0];
            end
            if (idx == WB_DATA) begin
                data_ff <= wb_dat_i[15:0];
            end
            if (idx == WB_RDADDR) begin
                rdAddr_ff <= wb_dat_i[PAGE_BITS+WORD_BITS-1:0];
            end
            if (idx == WB_STATUS) begin
                eeBusy_ff <= wb_dat_i[2];
            end
        end
    end

    // Command write then store instruction on the next cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_ff <= CMD_IDLE;
            ctrlWe_ff <= 1'b0;
            spm_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            ctrlWe_ff <= wrCtrl && !busy_ff && !dev.cpuHalt;
            spm_ff <= ctrlWe_ff;
            if (wrCtrl && !busy_ff && !dev.cpuHalt) begin
                ctrl_ff <= wb_dat_i[7:0];
                busy_ff <= 1'b1;
            end else if (spm_ff) begin
                busy_ff <= 1'b0;
            end
        end
    end
endmodule // fsps_host

// *** fsps_properties.sv ***
module fsps_properties #(
    parameter int PROG_CYCLES = 20
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Link signals
    input wire logic [7:0] ctrlWr,
    input wire logic ctrlWe,
    input wire logic spmExec,
    input wire logic eepromBusy,
    input wire logic cpuHalt,
    input wire logic [7:0] ctrlRd
);
    import fsps_pkg::*;
    int haltCnt_ff;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // Length of the current halt, read back when it ends
    always_ff @(posedge mclk) begin
        if (srst || !cpuHalt) begin
            haltCnt_ff <= 0;
        end else begin
            haltCnt_ff <= haltCnt_ff + 1;
        end
    end
    AST_ARM: assert property (ctrlWe && !eepromBusy && !cpuHalt && ctrlRd == CMD_IDLE
        |=> ctrlRd == $past(ctrlWr)) else $error("command not armed");
    AST_ERASE_HALT: assert property (spmExec && !eepromBusy && ctrlRd == CMD_ERASE
        |=> cpuHalt [*8]) else $error("erase did not halt");
    AST_WRITE_HALT: assert property (spmExec && !eepromBusy && ctrlRd == CMD_WRITE
        |=> cpuHalt [*8]) else $error("write did not halt");
    AST_HALT_LEN: assert property ($fell(cpuHalt) |-> haltCnt_ff == PROG_CYCLES)
        else $error("wrong halt length");
    AST_LOAD_DONE: assert property (spmExec && ctrlRd == CMD_LOAD
        |=> ctrlRd == CMD_IDLE && !cpuHalt) else $error("load did not complete");
    AST_BUSY_BLOCK: assert property (ctrlWe && eepromBusy |=> ctrlRd == CMD_IDLE)
        else $error("armed while eeprom busy");
    AST_EXPIRE: assert property (ctrlWe && !eepromBusy ##1 !spmExec [*4]
        |=> ctrlRd == CMD_IDLE) else $error("command did not expire");
    AST_HALT_CAUSE: assert property ($rose(cpuHalt) |-> $past(spmExec))
        else $error("halt without store");
    cover property (spmExec && ctrlRd == CMD_LOAD);
    cover property (spmExec && ctrlRd == CMD_ERASE);
    cover property (spmExec && ctrlRd == CMD_WRITE);
endmodule // fsps_properties

// *** fsps_test.sv ***
module fsps_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fsps_pkg::*;
    logic mclk, srst, cyc, stb, wen, ack;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q, rv;
    int mismatches, nTests;
    fsps_if link();
    fsps_host u_fsps_host (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .dev(link.host));
    fsps_device #(.PROG_CYCLES(20)) u_fsps_device (.mclk(mclk), .srst(srst), .core(link.device));
    fsps_properties #(.PROG_CYCLES(20)) u_fsps_properties (.mclk(mclk), .srst(srst), .ctrlWr(link.ctrlWr),
        .ctrlWe(link.ctrlWe), .spmExec(link.spmExec), .eepromBusy(link.eepromBusy), .cpuHalt(link.cpuHalt),
        .ctrlRd(link.ctrlRd));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; the watchdog bounds the wait for ack
    task automatic wb(input logic we, input logic [2:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        wen <= we;
        sel <= 4'hf;
        adr <= {a, 2'b00};
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        sel <= 4'h0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic spm(input logic [7:0] cmd, input logic [7:0] pg, input logic [5:0] w, input logic [15:0] d);
        wb(1'b1, WB_ZPTR, {17'h0, pg, w, 1'b0});
        wb(1'b1, WB_DATA, {16'h0, d});
        wb(1'b1, WB_CTRL, {24'h0, cmd});
        do wb(1'b0, WB_STATUS, 32'h0); while (q[1:0] !== 2'b00);
    endtask
    task automatic word(input logic [7:0] pg, input logic [5:0] w, output logic [31:0] v);
        wb(1'b1, WB_RDADDR, {18'h0, pg, w});
        wb(1'b0, WB_RDDATA, 32'h0);
        v = q;
    endtask
    task automatic testPage();
        logic [31:0] v;
        spm(CMD_LOAD, 8'h05, 6'h03, 16'h1234);
        spm(CMD_ERASE, 8'h05, 6'h2a, 16'h0f0f);
        spm(CMD_LOAD, 8'h05, 6'h01, 16'ha5c3);
        spm(CMD_WRITE, 8'h05, 6'h00, 16'h5555);
        word(8'h05, 6'h03, v);
        check(v, 32'h1234);
        word(8'h05, 6'h01, v);
        check(v, 32'ha5c3);
        word(8'h05, 6'h2a, v);
        check(v, {16'h0, WORD_ERASED});
    endtask
    task automatic testClear(input logic [7:0] pg, input logic [5:0] w);
        logic [31:0] v;
        spm(CMD_ERASE, pg, 6'h00, 16'h0);
        spm(CMD_WRITE, pg, 6'h00, 16'h0);
        word(pg, w, v);
        check(v, {16'h0, WORD_ERASED});
    endtask
    task automatic stopTest();
        if (mismatches == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        srst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        wen = 1'b0;
        sel = 4'h0;
        adr = 5'h00;
        wdat = 32'h0;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        wb(1'b0, WB_STATUS, 32'h0);
        check(q, 32'h0);
        wb(1'b0, 3'h6, 32'h0);
        check(q, WB_UNMAPPED);
        testPage();
        // Buffer must be empty after the write on page 5
        testClear(8'h06, 6'h03);
        spm(CMD_LOAD, 8'h08, 6'h04, 16'hbeef);
        spm(CMD_REENABLE, 8'h08, 6'h00, 16'h0);
        testClear(8'h08, 6'h04);
        spm(CMD_LOAD, 8'h07, 6'h02, 16'h1234);
        wb(1'b1, WB_STATUS, 32'h4);
        spm(CMD_WRITE, 8'h07, 6'h00, 16'h0);
        check(q, 32'h4);
        // Page 5 must survive an erase tried while EEPROM busy
        spm(CMD_ERASE, 8'h05, 6'h00, 16'h0);
        word(8'h05, 6'h03, rv);
        check(rv, 32'h1234);
        wb(1'b1, WB_STATUS, 32'h0);
        testClear(8'h07, 6'h02);
        stopTest();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        stopTest();
    end
endmodule // fsps_test
